// ==== fsq_consts.svh ====
// Named constants for the flash row write-latch sequencer
`ifndef FSQ_CONSTS_SVH
`define FSQ_CONSTS_SVH

`define FSQ_CLK_PERIOD_NS 25
`define FSQ_ERASE_TIME_US 2000
`define FSQ_PROG_TIME_US 2000

`define FSQ_REG_ADDR_W 3
`define FSQ_OFS_ADDR_LOW 3'h0
`define FSQ_OFS_ADDR_HIGH 3'h1
`define FSQ_OFS_DATA_LOW 3'h2
`define FSQ_OFS_DATA_HIGH 3'h3
`define FSQ_OFS_CONTROL_ONE 3'h4
`define FSQ_OFS_UNLOCK_KEY 3'h5

`define FSQ_KEY_FIRST 8'h55
`define FSQ_KEY_SECOND 8'hAA
`define FSQ_BLANK_WORD 14'h3FFF
`define FSQ_ZERO_BYTE 8'h00

`define FSQ_BIT_CONFIG_SPACE_SELECT 6
`define FSQ_BIT_LATCH_LOAD_ONLY 5
`define FSQ_BIT_FREE 4
`define FSQ_BIT_ERR 3
`define FSQ_BIT_PROGRAM_ERASE_ENABLE 2
`define FSQ_BIT_WR 1

`define FSQ_WORD_W 14
`define FSQ_LATCHES 32
`define FSQ_LATCH_IDX_W 5
`define FSQ_ROW_W 10
`define FSQ_ADDR_HIGH_W 7
`define FSQ_DATA_HIGH_W 6
`define FSQ_CNT_W 17

`endif

// ==== fsq_flash_model.sv ====
// Flash array model: reads the latches on a program pulse, blanks a row on erase
`timescale 1ns/1ps
module fsq_flash_model (
  input wire logic clk,
  input wire logic [9:0] row,
  input wire logic prog_stb,
  input wire logic erase_stb,
  input wire logic [13:0] latch_data,
  output logic [4:0] latch_sel
);
  logic [13:0] mem [int];
  logic [9:0] row_r = 10'h000;
  int scan = 0;
  initial latch_sel = 5'h1F;
  function automatic logic [13:0] peek(input logic [9:0] r, input logic [4:0] i);
    return mem.exists({r, i}) ? mem[{r, i}] : 14'h3FFF;
  endfunction
  always @(posedge clk) begin
    if (erase_stb) begin
      // Whole row only, never a neighbour
      for (int i = 0; i < 32; i++) mem[{row, 5'(i)}] = 14'h3FFF;
    end
    if (prog_stb) begin
      row_r <= row;
      scan <= 1;
      latch_sel <= 5'h00;
    end else if (scan != 0) begin
      // Programming only clears bits; no erase happens first
      if (scan >= 2) mem[{row_r, 5'(scan - 2)}] = peek(row_r, 5'(scan - 2)) & latch_data;
      latch_sel <= 5'(scan);
      scan <= (scan == 33) ? 0 : scan + 1;
    end
  end
endmodule

// ==== fsq_pkg.sv ====
// Types shared by the flash row write-latch sequencer
`include "fsq_consts.svh"
package fsq_pkg;
  typedef enum logic [2:0] {
    FSQ_IDLE = 3'b000,
    FSQ_KEY1 = 3'b001,
    FSQ_KEY2 = 3'b010,
    FSQ_NOP1 = 3'b011,
    FSQ_NOP2 = 3'b100,
    FSQ_BUSY = 3'b101
  } fsq_state_e;

  typedef logic [`FSQ_CNT_W-1:0] fsq_cnt_t;
  typedef logic [`FSQ_LATCHES-1:0][`FSQ_WORD_W-1:0] fsq_latch_t;

  typedef struct packed {
    fsq_state_e state;
    fsq_cnt_t cnt;
    logic [7:0] addr_low;
    logic [`FSQ_ADDR_HIGH_W-1:0] addr_high;
    logic [7:0] data_low;
    logic [`FSQ_DATA_HIGH_W-1:0] data_high;
    logic config_space_select;
    logic latch_load_only;
    logic free;
    logic err;
    logic program_erase_enable;
    logic wr;
    logic op_prog;
    logic op_erase;
    logic [`FSQ_ROW_W-1:0] row;
    logic prog_stb;
    logic erase_stb;
    logic [7:0] rdata;
    logic [`FSQ_WORD_W-1:0] latch_dout;
    fsq_latch_t latch;
  } fsq_regs_s;
endpackage

// ==== fsq_row_write_seq.sv ====
// Flash row write-latch sequencer: registers, unlock sequence, latches and self-timed op
// What this block does
// - Upper ten address bits pick the row; lower five pick the latch.
// - One operation touches only the selected row, never a neighbour.
// - Every latch returns to 0x3FFF when a program or erase finishes.
// - Unloaded latches stay blank and are programmed as blank words.
// - Starting a program never erases the row first.
// - Erase always covers exactly one whole row.
// - One program writes between one and 32 words, the latch count.
// - Latch-only set: completed sequence loads the addressed latch, no programming.
// - Latch-only clear: sequence loads the latch then programs the whole row.
// - Nothing loads or programs unless the unlock sequence completes intact.
// - Trigger forces two no-ops, then the core stalls until a program or erase completes.
// - Any count from one word to a full row is accepted per operation.
// - Trigger can be set but not cleared by software; hardware clears it.
// - A trigger after an improper or aborted sequence sets a sticky error flag.
// - Erase-select picks erase or write; hardware clears it at completion.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "fsq_consts.svh"
module fsq_row_write_seq #(
  parameter int ERASE_CYCLES = `FSQ_ERASE_TIME_US * 1000 / `FSQ_CLK_PERIOD_NS,
  parameter int PROG_CYCLES = `FSQ_PROG_TIME_US * 1000 / `FSQ_CLK_PERIOD_NS
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [`FSQ_REG_ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR_STB,
  input wire logic REG_RD_STB,
  output logic [7:0] REG_RDATA,
  output logic CORE_FORCE_NOP,
  output logic CORE_STALL,
  output logic FLASH_BUSY,
  output logic FLASH_PROG_STB,
  output logic FLASH_ERASE_STB,
  output logic [`FSQ_ROW_W-1:0] FLASH_ROW,
  input wire logic [`FSQ_LATCH_IDX_W-1:0] FLASH_LATCH_SEL,
  output logic [`FSQ_WORD_W-1:0] FLASH_LATCH_DATA
);

  fsq_pkg::fsq_regs_s s_r;
  fsq_pkg::fsq_regs_s s_nxt;

  logic wr_addr_low;
  logic wr_addr_high;
  logic wr_data_low;
  logic wr_data_high;
  logic wr_control;
  logic wr_key;
  logic trig_attempt;
  logic seq_ok;
  logic op_done;
  logic [`FSQ_LATCH_IDX_W-1:0] load_idx;

  // Register writes are ignored while the row operation runs, so row and data stay fixed
  assign wr_addr_low = REG_WR_STB && REG_ADDR == `FSQ_OFS_ADDR_LOW &&
                       s_r.state != fsq_pkg::FSQ_BUSY;
  assign wr_addr_high = REG_WR_STB && REG_ADDR == `FSQ_OFS_ADDR_HIGH &&
                        s_r.state != fsq_pkg::FSQ_BUSY;
  assign wr_data_low = REG_WR_STB && REG_ADDR == `FSQ_OFS_DATA_LOW &&
                       s_r.state != fsq_pkg::FSQ_BUSY;
  assign wr_data_high = REG_WR_STB && REG_ADDR == `FSQ_OFS_DATA_HIGH &&
                        s_r.state != fsq_pkg::FSQ_BUSY;
  assign wr_control = REG_WR_STB && REG_ADDR == `FSQ_OFS_CONTROL_ONE &&
                      s_r.state != fsq_pkg::FSQ_BUSY;
  assign wr_key = REG_WR_STB && REG_ADDR == `FSQ_OFS_UNLOCK_KEY;
  assign trig_attempt = wr_control && REG_WDATA[`FSQ_BIT_WR];
  // Enable and config select are judged as they stood before this write
  assign seq_ok = trig_attempt && s_r.state == fsq_pkg::FSQ_KEY2 && s_r.program_erase_enable && !s_r.config_space_select &&
                  !s_r.wr;
  assign op_done = s_r.state == fsq_pkg::FSQ_BUSY && s_r.cnt == fsq_pkg::fsq_cnt_t'(1);
  assign load_idx = s_r.addr_low[`FSQ_LATCH_IDX_W-1:0];

  always_comb begin
    s_nxt = s_r;
    s_nxt.prog_stb = 1'b0;
    s_nxt.erase_stb = 1'b0;
    s_nxt.latch_dout = s_r.latch[FLASH_LATCH_SEL];

    if (wr_addr_low) begin
      s_nxt.addr_low = REG_WDATA;
    end
    if (wr_addr_high) begin
      s_nxt.addr_high = REG_WDATA[`FSQ_ADDR_HIGH_W-1:0];
    end
    if (wr_data_low) begin
      s_nxt.data_low = REG_WDATA;
    end
    if (wr_data_high) begin
      s_nxt.data_high = REG_WDATA[`FSQ_DATA_HIGH_W-1:0];
    end
    if (wr_control) begin
      s_nxt.config_space_select = REG_WDATA[`FSQ_BIT_CONFIG_SPACE_SELECT];
      s_nxt.latch_load_only = REG_WDATA[`FSQ_BIT_LATCH_LOAD_ONLY];
      s_nxt.free = REG_WDATA[`FSQ_BIT_FREE];
      s_nxt.err = REG_WDATA[`FSQ_BIT_ERR];
      s_nxt.program_erase_enable = REG_WDATA[`FSQ_BIT_PROGRAM_ERASE_ENABLE];
      // A zero written to the trigger is dropped; only hardware clears it
      s_nxt.wr = s_r.wr;
    end

    // Hardware set beats a software clear of the error flag in the same cycle
    if (trig_attempt && !seq_ok) begin
      s_nxt.err = 1'b1;
    end

    case (s_r.state)
      fsq_pkg::FSQ_IDLE: begin
        if (wr_key && REG_WDATA == `FSQ_KEY_FIRST) begin
          s_nxt.state = fsq_pkg::FSQ_KEY1;
        end
      end
      fsq_pkg::FSQ_KEY1: begin
        if (wr_key && REG_WDATA == `FSQ_KEY_SECOND) begin
          s_nxt.state = fsq_pkg::FSQ_KEY2;
        end else if (wr_key && REG_WDATA == `FSQ_KEY_FIRST) begin
          s_nxt.state = fsq_pkg::FSQ_KEY1;
        end else begin
          s_nxt.state = fsq_pkg::FSQ_IDLE;
        end
      end
      fsq_pkg::FSQ_KEY2: begin
        if (seq_ok) begin
          s_nxt.state = fsq_pkg::FSQ_NOP1;
          s_nxt.wr = 1'b1;
          s_nxt.op_erase = s_r.free;
          s_nxt.op_prog = !s_r.free && !s_r.latch_load_only;
          // The whole row index is frozen here for the operation
          s_nxt.row = {s_r.addr_high, s_r.addr_low[7:`FSQ_LATCH_IDX_W]};
          if (!s_r.free) begin
            s_nxt.latch[load_idx] = {s_r.data_high, s_r.data_low};
          end
        end else if (wr_key && REG_WDATA == `FSQ_KEY_FIRST) begin
          s_nxt.state = fsq_pkg::FSQ_KEY1;
        end else begin
          s_nxt.state = fsq_pkg::FSQ_IDLE;
        end
      end
      fsq_pkg::FSQ_NOP1: begin
        s_nxt.state = fsq_pkg::FSQ_NOP2;
      end
      fsq_pkg::FSQ_NOP2: begin
        if (s_r.op_prog || s_r.op_erase) begin
          s_nxt.state = fsq_pkg::FSQ_BUSY;
          // Program and erase are separate strobes: a program never erases first
          s_nxt.prog_stb = s_r.op_prog;
          s_nxt.erase_stb = s_r.op_erase;
          s_nxt.cnt = s_r.op_erase ? fsq_pkg::fsq_cnt_t'(ERASE_CYCLES) :
                                     fsq_pkg::fsq_cnt_t'(PROG_CYCLES);
        end else begin
          // Latch load only: nothing goes to the array
          s_nxt.state = fsq_pkg::FSQ_IDLE;
          s_nxt.wr = 1'b0;
        end
      end
      fsq_pkg::FSQ_BUSY: begin
        s_nxt.cnt = s_r.cnt - fsq_pkg::fsq_cnt_t'(1);
        if (op_done) begin
          s_nxt.state = fsq_pkg::FSQ_IDLE;
          s_nxt.wr = 1'b0;
          s_nxt.op_prog = 1'b0;
          s_nxt.op_erase = 1'b0;
          if (s_r.op_erase) begin
            s_nxt.free = 1'b0;
          end
          for (int i = 0; i < `FSQ_LATCHES; i++) begin
            s_nxt.latch[i] = `FSQ_BLANK_WORD;
          end
        end
      end
      default: begin
        s_nxt.state = fsq_pkg::FSQ_IDLE;
      end
    endcase

    if (REG_RD_STB) begin
      case (REG_ADDR)
        `FSQ_OFS_ADDR_LOW: s_nxt.rdata = s_r.addr_low;
        `FSQ_OFS_ADDR_HIGH: s_nxt.rdata = {1'b1, s_r.addr_high};
        `FSQ_OFS_DATA_LOW: s_nxt.rdata = s_r.data_low;
        `FSQ_OFS_DATA_HIGH: s_nxt.rdata = {2'b00, s_r.data_high};
        `FSQ_OFS_CONTROL_ONE: begin
          s_nxt.rdata = {1'b1, s_r.config_space_select, s_r.latch_load_only, s_r.free, s_r.err, s_r.program_erase_enable, s_r.wr, 1'b0};
        end
        default: s_nxt.rdata = `FSQ_ZERO_BYTE;
      endcase
    end else begin
      s_nxt.rdata = `FSQ_ZERO_BYTE;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      s_r <= '0;
      // Latches power up blank so a partial load programs blank words elsewhere
      s_r.latch <= {`FSQ_LATCHES{`FSQ_BLANK_WORD}};
      s_r.state <= fsq_pkg::FSQ_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA = s_r.rdata;
  assign CORE_FORCE_NOP = s_r.state == fsq_pkg::FSQ_NOP1 || s_r.state == fsq_pkg::FSQ_NOP2;
  assign CORE_STALL = s_r.state == fsq_pkg::FSQ_BUSY;
  assign FLASH_BUSY = s_r.state == fsq_pkg::FSQ_BUSY;
  assign FLASH_PROG_STB = s_r.prog_stb;
  assign FLASH_ERASE_STB = s_r.erase_stb;
  assign FLASH_ROW = s_r.row;
  assign FLASH_LATCH_DATA = s_r.latch_dout;

  chk_latch_blank_done: assert property (@(posedge REF_CLK) disable iff (RESET)
    op_done |=> s_r.latch == {`FSQ_LATCHES{`FSQ_BLANK_WORD}})
    else $error("latches not blank after operation");

  chk_load_only_quiet: assert property (@(posedge REF_CLK) disable iff (RESET)
    (seq_ok && s_r.latch_load_only && !s_r.free) |=> !FLASH_PROG_STB [*3] ##1 !CORE_STALL)
    else $error("latch-only load started programming");

  chk_full_program: assert property (@(posedge REF_CLK) disable iff (RESET)
    (seq_ok && !s_r.latch_load_only && !s_r.free) |=> ##2 FLASH_PROG_STB && CORE_STALL)
    else $error("program did not start after latch load");

  chk_bad_trigger: assert property (@(posedge REF_CLK) disable iff (RESET)
    (trig_attempt && !seq_ok) |=> s_r.err && !CORE_FORCE_NOP && $stable(s_r.latch))
    else $error("broken sequence acted or left no error");

  chk_nop_pair: assert property (@(posedge REF_CLK) disable iff (RESET)
    seq_ok |=> CORE_FORCE_NOP [*2] ##1 !CORE_FORCE_NOP)
    else $error("forced no-op window not two cycles");

  chk_trigger_held: assert property (@(posedge REF_CLK) disable iff (RESET)
    (s_r.wr && !op_done && s_r.state != fsq_pkg::FSQ_NOP2) |=> s_r.wr)
    else $error("trigger cleared before completion");

  chk_key_timeout: assert property (@(posedge REF_CLK) disable iff (RESET)
    (s_r.state == fsq_pkg::FSQ_KEY1 && !wr_key) |=> s_r.state == fsq_pkg::FSQ_IDLE)
    else $error("unlock kept alive over a gap");

  chk_row_stable: assert property (@(posedge REF_CLK) disable iff (RESET)
    (FLASH_BUSY && $past(FLASH_BUSY)) |-> $stable(FLASH_ROW))
    else $error("row changed during operation");

  chk_prog_no_erase: assert property (@(posedge REF_CLK) disable iff (RESET)
    FLASH_PROG_STB |-> !FLASH_ERASE_STB)
    else $error("program strobe came with erase");

  chk_free_clear: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_done && s_r.op_erase) |=> !s_r.free && !s_r.wr)
    else $error("erase select not cleared at completion");

endmodule

// ==== test_flash_row_write_latch_sequencer.sv ====
// Self-checking bench for the flash row write-latch sequencer
`timescale 1ns/1ps
`include "fsq_consts.svh"
module test_flash_row_write_latch_sequencer;
  localparam int PROGN = 40;
  localparam int ERASEN = 8;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [2:0] REG_ADDR = 3'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR_STB = 1'b0;
  logic REG_RD_STB = 1'b0;
  logic [7:0] REG_RDATA;
  logic CORE_FORCE_NOP, CORE_STALL, FLASH_BUSY, FLASH_PROG_STB, FLASH_ERASE_STB;
  logic [9:0] FLASH_ROW;
  logic [4:0] FLASH_LATCH_SEL;
  logic [13:0] FLASH_LATCH_DATA;
  int n_fail = 0;
  int num_checks = 0;
  fsq_row_write_seq #(.ERASE_CYCLES(ERASEN), .PROG_CYCLES(PROGN)) fsq_row_write_seq_i (
    .REF_CLK(REF_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR_STB(REG_WR_STB), .REG_RD_STB(REG_RD_STB), .REG_RDATA(REG_RDATA),
    .CORE_FORCE_NOP(CORE_FORCE_NOP), .CORE_STALL(CORE_STALL), .FLASH_BUSY(FLASH_BUSY),
    .FLASH_PROG_STB(FLASH_PROG_STB), .FLASH_ERASE_STB(FLASH_ERASE_STB),
    .FLASH_ROW(FLASH_ROW), .FLASH_LATCH_SEL(FLASH_LATCH_SEL),
    .FLASH_LATCH_DATA(FLASH_LATCH_DATA));
  fsq_flash_model fsq_flash_model_i (.clk(REF_CLK), .row(FLASH_ROW), .prog_stb(FLASH_PROG_STB),
    .erase_stb(FLASH_ERASE_STB), .latch_data(FLASH_LATCH_DATA), .latch_sel(FLASH_LATCH_SEL));
  initial forever #12.5 REF_CLK = ~REF_CLK;
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One bus cycle; every strobe is assigned once per edge so cycles can abut
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    REG_WR_STB <= w;
    REG_RD_STB <= r;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    #1 chk(14'(REG_RDATA), 14'(exp));
  endtask
  task automatic load_word(input logic [9:0] row, input logic [4:0] idx, input logic [13:0] d);
    bus(1'b1, 1'b0, `FSQ_OFS_ADDR_LOW, {row[2:0], idx});
    bus(1'b1, 1'b0, `FSQ_OFS_ADDR_HIGH, {1'b0, row[9:3]});
    bus(1'b1, 1'b0, `FSQ_OFS_DATA_LOW, d[7:0]);
    bus(1'b1, 1'b0, `FSQ_OFS_DATA_HIGH, {2'b00, d[13:8]});
  endtask
  // Mode bits, keys, then trigger; op: 0 none, 1 program, 2 erase; gap reads between keys
  // The mode is written ahead: the block judges the mode bits as they stood before the trigger
  task automatic trig(input logic [7:0] ctrl, input bit ok, input int op, input bit gap);
    int n;
    bus(1'b1, 1'b0, `FSQ_OFS_CONTROL_ONE, ctrl);
    bus(1'b1, 1'b0, `FSQ_OFS_UNLOCK_KEY, `FSQ_KEY_FIRST);
    if (gap) bus(1'b0, 1'b1, `FSQ_OFS_ADDR_LOW, 8'h00);
    bus(1'b1, 1'b0, `FSQ_OFS_UNLOCK_KEY, `FSQ_KEY_SECOND);
    bus(1'b1, 1'b0, `FSQ_OFS_CONTROL_ONE, ctrl | 8'h02);
    #1 chk(14'(CORE_FORCE_NOP), 14'(ok));
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    #1 chk(14'(CORE_FORCE_NOP), 14'(ok));
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    #1 chk(14'(CORE_FORCE_NOP), 14'h0);
    chk(14'(FLASH_PROG_STB), 14'(op == 1));
    chk(14'(FLASH_ERASE_STB), 14'(op == 2));
    chk(14'(CORE_STALL), 14'(op != 0));
    chk(14'(FLASH_BUSY), 14'(op != 0));
    n = 0;
    while (CORE_STALL === 1'b1 && n < 200) begin
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      n++;
      #1;
    end
    chk(14'(n), op == 1 ? 14'(PROGN) : op == 2 ? 14'(ERASEN) : 14'h0);
  endtask
  task automatic t_reset_values();
    rd(`FSQ_OFS_ADDR_LOW, 8'h00);
    rd(`FSQ_OFS_ADDR_HIGH, 8'h80);
    rd(`FSQ_OFS_CONTROL_ONE, 8'h80);
    rd(`FSQ_OFS_UNLOCK_KEY, 8'h00);
    rd(3'h6, 8'h00);
  endtask
  task automatic t_broken_unlock();
    bus(1'b1, 1'b0, `FSQ_OFS_CONTROL_ONE, 8'h24);
    load_word(10'h155, 5'h02, 14'h0123);
    trig(8'h24, 1'b0, 0, 1'b1);
    rd(`FSQ_OFS_CONTROL_ONE, 8'hAC);
    bus(1'b1, 1'b0, `FSQ_OFS_CONTROL_ONE, 8'h20);
    trig(8'h20, 1'b0, 0, 1'b0);
    rd(`FSQ_OFS_CONTROL_ONE, 8'hA8);
    trig(8'h64, 1'b0, 0, 1'b0);
    rd(`FSQ_OFS_CONTROL_ONE, 8'hEC);
    bus(1'b1, 1'b0, `FSQ_OFS_CONTROL_ONE, 8'h24);
  endtask
  task automatic t_program_rows();
    load_word(10'h2A5, 5'h03, 14'h1234);
    trig(8'h24, 1'b1, 0, 1'b0);
    rd(`FSQ_OFS_CONTROL_ONE, 8'hA4);
    load_word(10'h2A5, 5'h1F, 14'h0ABC);
    trig(8'h04, 1'b1, 1, 1'b0);
    chk(fsq_flash_model_i.peek(10'h2A5, 5'h03), 14'h1234);
    chk(fsq_flash_model_i.peek(10'h2A5, 5'h1F), 14'h0ABC);
    chk(fsq_flash_model_i.peek(10'h2A5, 5'h02), 14'h3FFF);
    chk(fsq_flash_model_i.peek(10'h2A5, 5'h1E), 14'h3FFF);
    chk(fsq_flash_model_i.peek(10'h2A6, 5'h03), 14'h3FFF);
    load_word(10'h2A6, 5'h00, 14'h0555);
    rd(`FSQ_OFS_ADDR_HIGH, 8'hD4);
    rd(`FSQ_OFS_DATA_LOW, 8'h55);
    rd(`FSQ_OFS_DATA_HIGH, 8'h05);
    trig(8'h04, 1'b1, 1, 1'b0);
    chk(fsq_flash_model_i.peek(10'h2A6, 5'h00), 14'h0555);
    chk(fsq_flash_model_i.peek(10'h2A6, 5'h03), 14'h3FFF);
    chk(fsq_flash_model_i.peek(10'h2A6, 5'h1F), 14'h3FFF);
  endtask
  task automatic t_erase_row();
    bus(1'b1, 1'b0, `FSQ_OFS_ADDR_LOW, 8'hB0);
    trig(8'h14, 1'b1, 2, 1'b0);
    chk(fsq_flash_model_i.peek(10'h2A5, 5'h03), 14'h3FFF);
    chk(fsq_flash_model_i.peek(10'h2A6, 5'h00), 14'h0555);
    rd(`FSQ_OFS_CONTROL_ONE, 8'h84);
  endtask
  // Read-modify-write of one row, its one programmed word (index 0) saved by the bench across the erase
  task automatic t_modify_row();
    logic [13:0] img;
    img = fsq_flash_model_i.peek(10'h2A6, 5'h00);
    chk(img, 14'h0555);
    bus(1'b1, 1'b0, `FSQ_OFS_ADDR_LOW, 8'hC0);
    trig(8'h14, 1'b1, 2, 1'b0);
    chk(fsq_flash_model_i.peek(10'h2A6, 5'h00), 14'h3FFF);
    load_word(10'h2A6, 5'h00, img);
    trig(8'h24, 1'b1, 0, 1'b0);
    load_word(10'h2A6, 5'h05, 14'h0777);
    trig(8'h04, 1'b1, 1, 1'b0);
    chk(fsq_flash_model_i.peek(10'h2A6, 5'h00), 14'h0555);
    chk(fsq_flash_model_i.peek(10'h2A6, 5'h05), 14'h0777);
    chk(fsq_flash_model_i.peek(10'h2A5, 5'h1F), 14'h3FFF);
  endtask
  initial begin
    repeat (8) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    t_reset_values();
    t_broken_unlock();
    t_program_rows();
    t_erase_row();
    t_modify_row();
    wrap_up();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge REF_CLK);
    n_fail++;
    wrap_up();
  end
endmodule
